// file: alu_host_pkg.sv
// Purpose: Shared constants and types for the ALU slice controller.
// Assumes: Active-high operand, result and carry representation on all slice pins.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package alu_host_pkg;

	// ----------------------------------------
	// Slice and word geometry
	// ----------------------------------------
	localparam int SLICE_BITS = 4;
	localparam int FULL_LA_SLICES = 4;
	localparam int RIPPLE_BLOCK_SLICES = 3;
	localparam int ONES_MAX_SLICES = 3;
	localparam int AXI_ADDR_W = 8;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_OPA = 8'h04;
	localparam logic [7:0] OFF_OPB = 8'h08;
	localparam logic [7:0] OFF_RESULT = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;

	// Control fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_SHIFT_LSB = 4;
	localparam int CTRL_ARITH_BIT = 6;
	localparam int CTRL_ROTATE_BIT = 7;
	localparam int CTRL_GO_BIT = 31;
	localparam int SM_SIGN_BIT = 31;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_00FF;

	// Status fields
	localparam int ST_BUSY = 0;
	localparam int ST_GT = 1;
	localparam int ST_LT = 2;
	localparam int ST_EQ = 3;
	localparam int ST_WORD_EQ = 4;
	localparam int ST_CARRY = 5;
	localparam int ST_ERR = 6;
	localparam int ST_SIGN = 7;

	// ----------------------------------------
	// Select codes, active-high view {high, low}
	// ----------------------------------------
	localparam logic [1:0] SEL_SUB = 2'h0;
	localparam logic [1:0] SEL_ADD = 2'h1;
	localparam logic [1:0] SEL_CMP = 2'h2;
	localparam logic [1:0] SEL_OR = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {OP_ADD, OP_SUB, OP_RSUB, OP_CMP, OP_XOR, OP_OR,
		OP_ONES_ADD, OP_ONES_SUB, OP_SM_ADD, OP_SM_SUB} op_t;

	typedef enum logic [1:0] {SH_PASS, SH_UP, SH_DOWN, SH_SPARE} shift_t;

endpackage

// file: carry_chain.sv
// Purpose: Look-ahead carry network between cascaded slices.
// Assumes: Group outputs read in active-high form: x acts as propagate, y as generate.
// Notes: First four slices form one look-ahead group, then groups of three ripple.
`timescale 1ns/100ps
module carry_chain #(
	parameter int SLICES = 4
) (
	input wire logic [SLICES-1:0] aux_carry_x, // Propagate-like group output per slice
	input wire logic [SLICES-1:0] aux_carry_y, // Generate-like group output per slice
	input wire logic carry_first, // Carry into the least significant slice
	output logic [SLICES-1:0] slice_carry, // Carry into each slice
	output logic carry_msb // Carry out of the most significant slice
);
	import alu_host_pkg::*;

	function automatic int block_start(input int k);
		if (k < FULL_LA_SLICES)
			return 0;
		return k - ((k - FULL_LA_SLICES) % RIPPLE_BLOCK_SLICES);
	endfunction

	always_comb begin
		logic term;
		logic block_cin;
		int bs;
		term = 1'b0;
		block_cin = carry_first;
		bs = 0;
		slice_carry = '0;
		for (int k = 0; k < SLICES; k++) begin
			bs = block_start(k);
			if (k == bs && k != 0)
				block_cin = aux_carry_y[k-1] | (aux_carry_x[k-1] & slice_carry[k-1]);
			// Same wiring as true generate/propagate in either polarity
			term = block_cin;
			for (int j = bs; j < k; j++)
				term = aux_carry_y[j] | (aux_carry_x[j] & term);
			slice_carry[k] = term;
		end
		carry_msb = aux_carry_y[SLICES-1] | (aux_carry_x[SLICES-1] & slice_carry[SLICES-1]);
	end

endmodule

// file: result_shifter.sv
// Purpose: Four-way multiplexer shifter on the slice result.
// Assumes: "Up" moves bits toward the least significant end, "down" toward the most.
// Notes: Spare code inverts the word, used to turn A-B-1 into B-A.
`timescale 1ns/100ps
module result_shifter #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] data_in, // Raw slice result
	input wire alu_host_pkg::shift_t code, // Shift selection
	input wire logic arith, // Repeat sign bit on shift up
	input wire logic rotate, // Recirculate instead of zero fill
	output logic [WIDTH-1:0] data_out // Shifted word
);
	import alu_host_pkg::*;

	always_comb begin
		logic fill_hi;
		logic fill_lo;
		fill_hi = arith ? data_in[WIDTH-1] : (rotate ? data_in[0] : 1'b0);
		fill_lo = rotate ? data_in[WIDTH-1] : 1'b0;
		unique case (code)
			SH_PASS: data_out = data_in;
			SH_UP: data_out = {fill_hi, data_in[WIDTH-1:1]};
			SH_DOWN: data_out = {data_in[WIDTH-2:0], fill_lo};
			SH_SPARE: data_out = ~data_in;
		endcase
	end

endmodule

// file: alu_host.sv
// Purpose: Controller driving a chain of four-bit ALU slices, with AXI4-Lite registers.
// Assumes: Slices are combinational; their outputs settle within the cycle the pins are driven.
// Notes: Compare always runs two passes; one's complement takes a second on carry out, sign-magnitude on a negative difference.
// What this block does
// - Wire auxiliary carries like generate/propagate
// - Force first carry from low select
// - Invert low select into first carry
// - End-around carry, at most three slices
// - Four-slice look-ahead, then rippling three-slice blocks
// - External mux shifter: up, pass, down, spare
// - Spare code gives B minus A
// - Arithmetic repeats sign; logical zero or rotate
// - Subtract with carry; no carry means greater
// - Subtract without carry; carry means less
// - Equality: propagate set, generate clear, all slices
// - Second pass complements negative magnitude result
// - Unused top inputs: A low, B high on the first pass, both low on the second
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module alu_host #(
	parameter int SLICES = 4,
	parameter int WIDTH = SLICES * alu_host_pkg::SLICE_BITS,
	parameter int MAG_BITS = WIDTH - 1
) (
	input wire logic clk_sys, // System clock, 20 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [alu_host_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [alu_host_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic [WIDTH-1:0] operand_a, // A operand pins
	output logic [WIDTH-1:0] operand_b, // B operand pins
	output logic function_select_low, // Low function select to all slices
	output logic function_select_high, // High function select to all slices
	output logic [SLICES-1:0] slice_carry_in, // Carry into each slice
	output logic [SLICES-1:0] carry_out_enable, // Carry-out enable per slice
	input wire logic [WIDTH-1:0] slice_result, // Result pins of all slices
	input wire logic [SLICES-1:0] aux_carry_x, // Group generate pins, propagate-like
	input wire logic [SLICES-1:0] aux_carry_y // Group propagate pins, generate-like
);
	import alu_host_pkg::*;

	typedef enum {ST_IDLE, ST_PASS1, ST_PASS2} seq_t;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = data[i*8 +: 8];
		return r;
	endfunction

	// ----------------------------------------
	// Register bus state
	// ----------------------------------------
	logic [AXI_ADDR_W-1:0] awaddr_q, awaddr_d;
	logic aw_full_q, aw_full_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic w_full_q, w_full_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] opa_q, opa_d;
	logic [31:0] opb_q, opb_d;
	logic start_go;

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	seq_t state_q, state_d;
	op_t op_q, op_d;
	logic [1:0] sel_q, sel_d;
	logic force_q, force_d;
	logic around_q, around_d;
	logic [WIDTH-1:0] pin_a_q, pin_a_d;
	logic [WIDTH-1:0] pin_b_q, pin_b_d;
	logic [WIDTH-1:0] result_q, result_d;
	logic [7:0] status_q, status_d;
	logic eff_sub_q, eff_sub_d;

	logic carry_first;
	logic carry_msb;
	logic [WIDTH-1:0] shifted;
	shift_t shift_code;
	logic slice_eq_all;

	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_comb begin
		awaddr_d = awaddr_q;
		aw_full_d = aw_full_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		w_full_d = w_full_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		ctrl_d = ctrl_q;
		opa_d = opa_q;
		opb_d = opb_q;
		start_go = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_d = s_axi_awaddr;
			aw_full_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
			w_full_d = 1'b1;
		end
		if (aw_full_q && w_full_q && !bvalid_q) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			unique case (awaddr_q)
				OFF_CTRL: begin
					if (state_q != ST_IDLE)
						bresp_d = RESP_SLVERR;
					else begin
						ctrl_d = merge(ctrl_q, wdata_q, wstrb_q) & CTRL_WMASK;
						start_go = wstrb_q[3] && wdata_q[CTRL_GO_BIT];
					end
				end
				OFF_OPA: opa_d = merge(opa_q, wdata_q, wstrb_q);
				OFF_OPB: opb_d = merge(opb_q, wdata_q, wstrb_q);
				default: bresp_d = RESP_SLVERR;
			endcase
		end else if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = '0;
			unique case (s_axi_araddr)
				OFF_CTRL: rdata_d = ctrl_q;
				OFF_OPA: rdata_d = opa_q;
				OFF_OPB: rdata_d = opb_q;
				OFF_RESULT: rdata_d[WIDTH-1:0] = result_q;
				OFF_STATUS: rdata_d[7:0] = status_q;
				default: rresp_d = RESP_SLVERR;
			endcase
		end else if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			awaddr_q <= '0;
			aw_full_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			ctrl_q <= CTRL_RESET;
			opa_q <= '0;
			opb_q <= '0;
		end else begin
			awaddr_q <= awaddr_d;
			aw_full_q <= aw_full_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			w_full_q <= w_full_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl_q <= ctrl_d;
			opa_q <= opa_d;
			opb_q <= opb_d;
		end
	end

	// ----------------------------------------
	// Carry network and shifter
	// ----------------------------------------
	// Inverter from low select: forced carry only in subtract code
	assign carry_first = force_q ? !sel_q[0] : around_q;

	carry_chain #(.SLICES(SLICES)) u_chain (
		.aux_carry_x(aux_carry_x),
		.aux_carry_y(aux_carry_y),
		.carry_first(carry_first),
		.slice_carry(slice_carry_in),
		.carry_msb(carry_msb)
	);

	assign shift_code = (op_q == OP_RSUB) ? SH_SPARE : shift_t'(ctrl_q[CTRL_SHIFT_LSB +: 2]);

	result_shifter #(.WIDTH(WIDTH)) u_shift (
		.data_in(slice_result),
		.code(shift_code),
		.arith(ctrl_q[CTRL_ARITH_BIT]),
		.rotate(ctrl_q[CTRL_ROTATE_BIT]),
		.data_out(shifted)
	);

	// Propagate high, generate low on every slice in subtract mode
	assign slice_eq_all = &(aux_carry_x & ~aux_carry_y);

	// Carry-in handled by our own look-ahead, so the slice term stays off
	assign carry_out_enable = '0;
	assign operand_a = pin_a_q;
	assign operand_b = pin_b_q;
	assign function_select_low = sel_q[0];
	assign function_select_high = sel_q[1];

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	always_comb begin
		op_t op_new;
		logic sub_eff;
		op_new = op_t'(ctrl_d[CTRL_OP_LSB +: 4]);
		sub_eff = 1'b0;
		state_d = state_q;
		op_d = op_q;
		sel_d = sel_q;
		force_d = force_q;
		around_d = around_q;
		pin_a_d = pin_a_q;
		pin_b_d = pin_b_q;
		result_d = result_q;
		status_d = status_q;
		eff_sub_d = eff_sub_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start_go) begin
					op_d = op_new;
					status_d = '0;
					around_d = 1'b0;
					pin_a_d = opa_d[WIDTH-1:0];
					pin_b_d = opb_d[WIDTH-1:0];
					force_d = 1'b0;
					state_d = ST_PASS1;
					unique case (op_new)
						OP_ADD, OP_ONES_ADD: sel_d = SEL_ADD;
						OP_SUB, OP_CMP: begin
							sel_d = SEL_SUB;
							force_d = 1'b1;
						end
						OP_RSUB, OP_ONES_SUB: sel_d = SEL_SUB;
						OP_XOR: sel_d = SEL_CMP;
						OP_OR: sel_d = SEL_OR;
						OP_SM_ADD, OP_SM_SUB: begin
							sub_eff = opa_d[SM_SIGN_BIT] ^ opb_d[SM_SIGN_BIT] ^ (op_new == OP_SM_SUB);
							eff_sub_d = sub_eff;
							sel_d = sub_eff ? SEL_SUB : SEL_ADD;
							force_d = sub_eff;
							pin_a_d = '0;
							pin_b_d = '1;
							pin_a_d[MAG_BITS-1:0] = opa_d[MAG_BITS-1:0];
							pin_b_d[MAG_BITS-1:0] = opb_d[MAG_BITS-1:0];
						end
						default: begin
							status_d[ST_ERR] = 1'b1;
							state_d = ST_IDLE;
						end
					endcase
					if ((op_new == OP_ONES_ADD || op_new == OP_ONES_SUB) && SLICES > ONES_MAX_SLICES) begin
						status_d[ST_ERR] = 1'b1;
						state_d = ST_IDLE;
					end
					status_d[ST_BUSY] = (state_d != ST_IDLE);
				end
			end
			ST_PASS1: begin
				result_d = shifted;
				status_d[ST_CARRY] = carry_msb;
				status_d[ST_WORD_EQ] = slice_eq_all;
				state_d = ST_IDLE;
				status_d[ST_BUSY] = 1'b0;
				unique case (op_q)
					OP_CMP: begin
						status_d[ST_GT] = !carry_msb;
						force_d = 1'b0;
						state_d = ST_PASS2;
						status_d[ST_BUSY] = 1'b1;
					end
					OP_ONES_ADD, OP_ONES_SUB: begin
						if (carry_msb) begin
							around_d = 1'b1;
							state_d = ST_PASS2;
							status_d[ST_BUSY] = 1'b1;
						end
					end
					OP_SM_ADD, OP_SM_SUB: begin
						status_d[ST_SIGN] = opa_q[SM_SIGN_BIT];
						if (eff_sub_q && !slice_result[MAG_BITS]) begin
							status_d[ST_SIGN] = !opa_q[SM_SIGN_BIT];
							pin_a_d = '0;
							pin_b_d = '0;
							pin_b_d[MAG_BITS-1:0] = slice_result[MAG_BITS-1:0];
							sel_d = SEL_SUB;
							force_d = 1'b1;
							state_d = ST_PASS2;
							status_d[ST_BUSY] = 1'b1;
						end
					end
					default: ;
				endcase
			end
			ST_PASS2: begin
				state_d = ST_IDLE;
				status_d[ST_BUSY] = 1'b0;
				if (op_q == OP_CMP) begin
					status_d[ST_LT] = carry_msb;
					status_d[ST_EQ] = status_q[ST_GT] == 1'b0 && !carry_msb;
				end else begin
					result_d = shifted;
					status_d[ST_CARRY] = carry_msb;
				end
				around_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			op_q <= OP_ADD;
			sel_q <= SEL_ADD;
			force_q <= 1'b0;
			around_q <= 1'b0;
			pin_a_q <= '0;
			pin_b_q <= '0;
			result_q <= '0;
			status_q <= '0;
			eff_sub_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			sel_q <= sel_d;
			force_q <= force_d;
			around_q <= around_d;
			pin_a_q <= pin_a_d;
			pin_b_q <= pin_b_d;
			result_q <= result_d;
			status_q <= status_d;
			eff_sub_q <= eff_sub_d;
		end
	end

endmodule

// file: slice_chain_model.sv
// Purpose: Behavioural chain of four-bit slices on active-high pins.
// Assumes: Every slice sees the same two selects.
// Notes: x is carry-out with carry-in set, or with the slice carry when carry-out enable is set; y with carry-in clear.
`timescale 1ns/100ps
module slice_chain_model #(
	parameter int SLICES = 4
) (
	input wire logic [SLICES*4-1:0] operand_a, // A pins
	input wire logic [SLICES*4-1:0] operand_b, // B pins
	input wire logic function_select_low, // Low select
	input wire logic function_select_high, // High select
	input wire logic [SLICES-1:0] slice_carry_in, // Carry per slice
	input wire logic [SLICES-1:0] carry_out_enable, // Carry-out enable
	output logic [SLICES*4-1:0] slice_result, // Result pins
	output logic [SLICES-1:0] aux_carry_x, // Propagate-like
	output logic [SLICES-1:0] aux_carry_y // Generate-like
);
	logic [3:0] a, b;
	logic [4:0] s1, s0, sc;
	// No state anywhere, outputs follow pins
	always_comb begin
		for (int k = 0; k < SLICES; k++) begin
			a = operand_a[4*k+:4];
			b = function_select_low ? operand_b[4*k+:4] : ~operand_b[4*k+:4];
			s1 = a + b + 5'h01;
			s0 = a + b;
			sc = a + b + slice_carry_in[k];
			// Carry-in reaches x only through the enabled term
			aux_carry_x[k] = carry_out_enable[k] ? sc[4] : s1[4];
			aux_carry_y[k] = s0[4];
			if (!function_select_high) begin
				slice_result[4*k+:4] = sc[3:0];
			end else if (function_select_low) begin
				slice_result[4*k+:4] = a | operand_b[4*k+:4];
			end else begin
				slice_result[4*k+:4] = ~(a ^ operand_b[4*k+:4]);
			end
		end
	end
endmodule

// file: alu_host_props.sv
// Purpose: Port assertions for the slice controller.
// Assumes: One clock domain, reset active low.
// Notes: Carry check holds for either look-ahead form.
`timescale 1ns/100ps
module alu_host_props #(
	parameter int SLICES = 4
) (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic [1:0] s_axi_bresp, // B resp
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic [1:0] s_axi_rresp, // R resp
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic function_select_low, // Low select
	input wire logic function_select_high, // High select
	input wire logic [SLICES-1:0] slice_carry_in, // Slice carries
	input wire logic [SLICES-1:0] aux_carry_x, // Propagate-like
	input wire logic [SLICES-1:0] aux_carry_y // Generate-like
);
	import alu_host_pkg::*;
	logic [SLICES-1:0] chain_exp;
	always_comb begin
		chain_exp = slice_carry_in;
		for (int k = 1; k < SLICES; k++) begin
			chain_exp[k] = aux_carry_y[k-1] | (aux_carry_x[k-1] & slice_carry_in[k-1]);
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_first_carry: assert property (function_select_low |-> !slice_carry_in[0])
		else $error("carry forced into first slice while adding");
	a_chain_carry: assert property (slice_carry_in == chain_exp)
		else $error("slice carry differs from chained aux outputs");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during response");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	c_sub: cover property (!function_select_high && !function_select_low && slice_carry_in[0]);
	c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind alu_host alu_host_props #(.SLICES(SLICES)) u_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .function_select_low(function_select_low),
	.function_select_high(function_select_high), .slice_carry_in(slice_carry_in),
	.aux_carry_x(aux_carry_x), .aux_carry_y(aux_carry_y));

// file: testbench.sv
// Purpose: Self-checking bench for the slice controller.
// Assumes: Partner model stands in for the slice chain.
// Notes: Ready raised only after valid seen, to exercise holds.
`timescale 1ns/100ps
module testbench;
	import alu_host_pkg::*;
	logic clk_sys;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, st, res;
	logic [15:0] operand_a, operand_b, slice_result, a, b;
	logic function_select_low, function_select_high, ar, ro;
	logic [3:0] slice_carry_in, carry_out_enable, aux_carry_x, aux_carry_y, op;
	logic [1:0] sh;
	logic [16:0] e;
	logic [3:0] ops [4] = '{OP_ADD, OP_SUB, OP_RSUB, OP_OR};
	logic [31:0] cmp_tab [4] = '{32'h0005_0005, 32'h0000_FFFF, 32'hFFFF_0000, 32'h1234_1233};
	int n_mismatch = 0;
	int num_checks = 0;

	alu_host dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .operand_a(operand_a), .operand_b(operand_b),
		.function_select_low(function_select_low), .function_select_high(function_select_high),
		.slice_carry_in(slice_carry_in), .carry_out_enable(carry_out_enable), .slice_result(slice_result),
		.aux_carry_x(aux_carry_x), .aux_carry_y(aux_carry_y));
	slice_chain_model partner (.operand_a(operand_a), .operand_b(operand_b),
		.function_select_low(function_select_low), .function_select_high(function_select_high),
		.slice_carry_in(slice_carry_in), .carry_out_enable(carry_out_enable), .slice_result(slice_result),
		.aux_carry_x(aux_carry_x), .aux_carry_y(aux_carry_y));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Handshakes judged from values settled before the edge
	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
		logic ta, tw, tb, tv;
		@(posedge clk_sys);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tv = s_axi_bvalid;
			tb = tv && s_axi_bready;
			rs = s_axi_bresp;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) begin
				s_axi_bready <= 1'b0;
				break;
			end
			if (tv) s_axi_bready <= 1'b1;
		end
	endtask

	task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
		logic ta, tr, tv;
		@(posedge clk_sys);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(negedge clk_sys);
			ta = s_axi_arvalid && s_axi_arready;
			tv = s_axi_rvalid;
			tr = tv && s_axi_rready;
			d = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) begin
				s_axi_rready <= 1'b0;
				break;
			end
			if (tv) s_axi_rready <= 1'b1;
		end
	endtask

	task automatic run_op(input logic [3:0] o, input logic [1:0] s, input logic r1, input logic r2,
		input logic [15:0] x, input logic [15:0] y);
		axi_wr(OFF_OPA, {16'h0000, x}, resp);
		axi_wr(OFF_OPB, {16'h0000, y}, resp);
		axi_wr(OFF_CTRL, {24'h80_0000, r2, r1, s, o}, resp);
		for (int i = 0; i < 20; i++) begin
			axi_rd(OFF_STATUS, st, resp);
			if (st[ST_BUSY] === 1'b0) break;
		end
		axi_rd(OFF_RESULT, res, resp);
	endtask

	function automatic logic [16:0] calc(input logic [3:0] o, input logic [15:0] x, input logic [15:0] y);
		case (o)
			OP_ADD: return {1'b0, x} + {1'b0, y};
			OP_SUB: return {1'b0, x} + {1'b0, ~y} + 17'h0_0001;
			OP_RSUB: return {1'b0, y - x};
			default: return {1'b0, x | y};
		endcase
	endfunction

	function automatic logic [15:0] shf(input logic [15:0] r, input logic [1:0] s, input logic r1, input logic r2);
		case (s)
			2'h1: return {r1 ? r[15] : (r2 ? r[0] : 1'b0), r[15:1]};
			2'h2: return {r[14:0], r2 ? r[15] : 1'b0};
			2'h3: return ~r;
			default: return r;
		endcase
	endfunction

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		a = 16'($urandom(14000));
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		check({14'h0, function_select_high, function_select_low, operand_a}, 32'h0001_0000);
		check({28'h0, carry_out_enable}, 32'h0000_0000);
		axi_rd(OFF_CTRL, st, resp);
		check(st, CTRL_RESET);
		$display("test reset done");
		axi_wr(OFF_CTRL, 32'h0000_00B5, resp);
		axi_rd(OFF_CTRL, st, resp);
		check(st, 32'h0000_00B5);
		axi_wr(OFF_RESULT, 32'h0000_0001, resp);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		axi_rd(8'h20, st, resp);
		check({resp, st[29:0]}, {RESP_SLVERR, 30'h0});
		run_op(OP_ONES_ADD, 2'h0, 1'b0, 1'b0, 16'h0001, 16'h0002);
		check({31'h0, st[ST_ERR]}, 32'h0000_0001);
		run_op(OP_XOR, 2'h0, 1'b0, 1'b0, 16'h00F0, 16'h0F0F);
		check({31'h0, st[ST_ERR]}, 32'h0000_0000);
		check(res, 32'h0000_F000);
		$display("test registers done");
		for (int i = 0; i < 32; i++) begin
			op = ops[i % 4];
			sh = 2'(i / 4);
			a = i == 0 ? 16'hFFFF : (i == 1 ? 16'h0000 : 16'($urandom));
			b = i < 2 ? 16'h0001 : 16'($urandom);
			ar = 1'($urandom);
			ro = ar ? 1'b0 : 1'($urandom);
			run_op(op, sh, ar, ro, a, b);
			e = calc(op, a, b);
			// Reverse subtract owns the spare code, so no shift applies
			check(res, {16'h0000, op == OP_RSUB ? e[15:0] : shf(e[15:0], sh, ar, ro)});
			if (op < 4'h2) check({31'h0, st[ST_CARRY]}, {31'h0, e[16]});
		end
		$display("test arithmetic done");
		for (int i = 0; i < 6; i++) begin
			{a, b} = i < 4 ? cmp_tab[i] : $urandom;
			run_op(OP_CMP, 2'h0, 1'b0, 1'b0, a, b);
			check({31'h0, st[ST_EQ]}, {31'h0, a == b});
			check({31'h0, st[ST_WORD_EQ]}, {31'h0, a == b});
			check({31'h0, st[ST_GT] ^ st[ST_LT]}, {31'h0, a != b});
		end
		$display("test compare done");
		run_op(OP_SM_SUB, 2'h0, 1'b0, 1'b0, 16'h0005, 16'h0009);
		check({st[ST_SIGN], 16'h0, res[14:0]}, 32'h8000_0004);
		run_op(OP_SM_ADD, 2'h0, 1'b0, 1'b0, 16'h0005, 16'h0009);
		check({st[ST_SIGN], 16'h0, res[14:0]}, 32'h0000_000E);
		$display("test sign magnitude done");
		report_and_stop();
	end
endmodule
